// ==== src/isr_route_top.sv ====
// interrupt routing and conditioning for four sources behind apb
// Function
// - passthrough set: raw source level goes straight to its destination.
// - passthrough set: inject bit and latching have no effect.
// - writing one to inject raises the source interrupt as if fired.
// - inject bit clears itself at once; reads return zero.
// - selector 0,1,2 pick icpu0, icpu1, ext0; 3 picks ext1 for analyzer.
`timescale 1ns/10ps
`default_nettype none
`include "isr_regs.svh"
module isr_route_top
   import isr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        all_ports_source,
   input  wire logic        analyzer_source,
   input  wire logic        extract_queue0_ready,
   input  wire logic        extract_queue1_ready,
   output logic             internal_cpu_line0,
   output logic             internal_cpu_line1,
   output logic             external_int_out0,
   output logic             external_int_out1,
   output logic             irq
);
   localparam int N = `ISR_NUM_SRC;

   // index of a config register, or -1 when the address is not one
   function automatic int cfg_index(input logic [11:0] a);
      if (a == `ISR_OFS_ALL_PORTS)
         return 0;
      else if (a == `ISR_OFS_ANALYZER)
         return 1;
      else if (a == `ISR_OFS_EXTRACT0)
         return 2;
      else if (a == `ISR_OFS_EXTRACT1)
         return 3;
      else
         return -1;
   endfunction : cfg_index

   isr_cfg_t    cfg_q [N];
   isr_cfg_t    cfg_d [N];
   logic [N-1:0] inject_q, inject_d;
   logic [N-1:0] ack;
   logic [N-1:0] level;
   logic [N-1:0] sticky;
   logic [N-1:0] stat_q, stat_d;
   logic [N-1:0] mask_q, mask_d;
   logic [N-1:0] raw;
   isr_dest_t   dest [N];
   isr_dest_t   lines_q, lines_d;
   logic        irq_q, irq_d;
   isr_apb_st_t st_q, st_d;
   logic [31:0] rdata_q, rdata_d;
   logic        err_q, err_d;
   logic        wr_hit, rd_hit;
   int          idx;

   assign raw = {extract_queue1_ready, extract_queue0_ready,
                 analyzer_source, all_ports_source};

   // per-source conditioning and routing
   for (genvar g = 0; g < N; g++) begin : g_src
      isr_src_cond u_cond (
         .clk_sys  (clk_sys),
         .reset    (reset),
         .raw_src  (raw[g]),
         .passthru (cfg_q[g].passthru),
         .inject   (inject_q[g] && !cfg_q[g].passthru),
         .ack      (ack[g]),
         .level    (level[g]),
         .sticky   (sticky[g])
      );
      isr_route_dec #(
         .HAS_EXT1 (g == `ISR_SRC_ANALYZER)
      ) u_dec (
         .dest_sel (cfg_q[g].dest_sel),
         .level    (level[g]),
         .dest     (dest[g])
      );
   end

   // apb access phase decode
   always_comb begin
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      if (psel && penable && st_q == ISR_APB_IDLE) begin
         wr_hit = pwrite;
         rd_hit = !pwrite;
      end
   end

   // apb handshake: one wait state, pready on the second access cycle
   always_comb begin
      st_d    = st_q;
      rdata_d = rdata_q;
      err_d   = 1'b0;
      if (st_q == ISR_APB_DONE) begin
         st_d    = ISR_APB_IDLE;
         rdata_d = `ISR_WORD_ZERO;
      end else if (psel && penable) begin
         st_d    = ISR_APB_DONE;
         idx     = cfg_index(paddr);
         rdata_d = `ISR_WORD_ZERO;
         if (idx >= 0) begin
            rdata_d[`ISR_BIT_PASSTHRU] = cfg_q[idx].passthru;
            rdata_d[`ISR_SEL_HI:`ISR_SEL_LO] = cfg_q[idx].dest_sel;
         end else if (paddr == `ISR_OFS_STATUS)
            rdata_d[N-1:0] = stat_q;
         else if (paddr == `ISR_OFS_MASK)
            rdata_d[N-1:0] = mask_q;
         else if (paddr == `ISR_OFS_PENDING)
            rdata_d[N-1:0] = sticky;
         else
            err_d = 1'b1;
      end
      if (!(psel && penable) && st_q == ISR_APB_IDLE)
         idx = -1;
      else
         idx = cfg_index(paddr);
   end

   // configuration, inject, acknowledge, status and mask updates
   always_comb begin
      for (int i = 0; i < N; i++) begin
         cfg_d[i] = cfg_q[i];
      end
      inject_d = '0;
      ack      = '0;
      mask_d   = mask_q;
      stat_d   = stat_q;
      if (wr_hit) begin
         for (int i = 0; i < N; i++) begin
            if (cfg_index(paddr) == i) begin
               cfg_d[i].passthru = pwdata[`ISR_BIT_PASSTHRU];
               cfg_d[i].dest_sel = pwdata[`ISR_SEL_HI:`ISR_SEL_LO];
               inject_d[i]       = pwdata[`ISR_BIT_INJECT];
            end
         end
         if (paddr == `ISR_OFS_PENDING)
            ack = pwdata[N-1:0];
         if (paddr == `ISR_OFS_MASK)
            mask_d = pwdata[N-1:0];
         if (paddr == `ISR_OFS_STATUS)
            stat_d = stat_q & ~pwdata[N-1:0];
      end
      // every latched source not in passthrough sets status each cycle; set wins over a clear
      stat_d = stat_d | (sticky & ~cfg_passthru_vec());
   end

   function automatic logic [N-1:0] cfg_passthru_vec();
      logic [N-1:0] v;
      v = '0;
      for (int i = 0; i < N; i++) begin
         v[i] = cfg_q[i].passthru;
      end
      return v;
   endfunction : cfg_passthru_vec

   // merge destinations and drive interrupt output
   always_comb begin
      lines_d = '0;
      for (int i = 0; i < N; i++) begin
         lines_d = lines_d | dest[i];
      end
      irq_d = |(stat_q & mask_q);
   end

   // registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < N; i++) begin
            cfg_q[i] <= `ISR_CFG_RESET;
         end
         inject_q <= '0;
         stat_q   <= '0;
         mask_q   <= '0;
         lines_q  <= '0;
         irq_q    <= 1'b0;
         st_q     <= ISR_APB_IDLE;
         rdata_q  <= `ISR_WORD_ZERO;
         err_q    <= 1'b0;
      end else begin
         for (int i = 0; i < N; i++) begin
            cfg_q[i] <= cfg_d[i];
         end
         inject_q <= inject_d;
         stat_q   <= stat_d;
         mask_q   <= mask_d;
         lines_q  <= lines_d;
         irq_q    <= irq_d;
         st_q     <= st_d;
         rdata_q  <= rdata_d;
         err_q    <= err_d;
      end
   end

   assign prdata             = rdata_q;
   assign pready             = (st_q == ISR_APB_DONE);
   assign pslverr            = err_q;
   assign internal_cpu_line0 = lines_q.icpu0;
   assign internal_cpu_line1 = lines_q.icpu1;
   assign external_int_out0  = lines_q.ext0;
   assign external_int_out1  = lines_q.ext1;
   assign irq                = irq_q;
endmodule : isr_route_top
`default_nettype wire

// ==== src/isr_regs.svh ====
// register offsets, field positions and reset values of the routing block
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH
`define ISR_OFS_ALL_PORTS   12'h000
`define ISR_OFS_ANALYZER    12'h004
`define ISR_OFS_EXTRACT0    12'h008
`define ISR_OFS_EXTRACT1    12'h00C
`define ISR_OFS_STATUS      12'h010
`define ISR_OFS_MASK        12'h014
`define ISR_OFS_PENDING     12'h018
`define ISR_BIT_PASSTHRU    4
`define ISR_BIT_INJECT      3
`define ISR_SEL_HI          1
`define ISR_SEL_LO          0
`define ISR_DEST_ICPU0      2'h0
`define ISR_DEST_ICPU1      2'h1
`define ISR_DEST_EXT0       2'h2
`define ISR_DEST_EXT1       2'h3
`define ISR_NUM_SRC         4
`define ISR_SRC_ANALYZER    1
`define ISR_CFG_RESET       3'h0
`define ISR_WORD_ZERO       32'h0000_0000
`endif

// ==== src/isr_pkg.sv ====
// types shared by the interrupt routing block
package isr_pkg;
   // per-source configuration word as stored
   typedef struct packed {
      logic       passthru;
      logic [1:0] dest_sel;
   } isr_cfg_t;

   // the four destination lines, bit order icpu0, icpu1, ext0, ext1
   typedef struct packed {
      logic ext1;
      logic ext0;
      logic icpu1;
      logic icpu0;
   } isr_dest_t;

   // apb slave state
   typedef enum logic [0:0] {
      ISR_APB_IDLE = 1'b0,
      ISR_APB_DONE = 1'b1
   } isr_apb_st_t;
endpackage : isr_pkg

// ==== src/isr_src_cond.sv ====
// one source: sticky latch, passthrough and inject conditioning
`timescale 1ns/10ps
`default_nettype none
`include "isr_regs.svh"
module isr_src_cond
   import isr_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic raw_src,
   input  wire logic passthru,
   input  wire logic inject,
   input  wire logic ack,
   output logic      level,
   output logic      sticky
);
   logic prev_q, prev_d;
   logic stick_q, stick_d;
   logic lvl_q, lvl_d;

   // rising edge or inject sets the latch; set beats acknowledge
   always_comb begin
      prev_d  = raw_src;
      stick_d = stick_q;
      if (ack)
         stick_d = 1'b0;
      if (!passthru && ((raw_src && !prev_q) || inject))
         stick_d = 1'b1;
      if (passthru)
         stick_d = 1'b0;
      lvl_d = passthru ? raw_src : stick_d;
   end

   // registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prev_q  <= 1'b0;
         stick_q <= 1'b0;
         lvl_q   <= 1'b0;
      end else begin
         prev_q  <= prev_d;
         stick_q <= stick_d;
         lvl_q   <= lvl_d;
      end
   end

   assign level  = lvl_q;
   assign sticky = stick_q;
endmodule : isr_src_cond
`default_nettype wire

// ==== src/isr_route_dec.sv ====
// destination decoder for one source
`timescale 1ns/10ps
`default_nettype none
`include "isr_regs.svh"
module isr_route_dec
   import isr_pkg::*;
#(
   parameter bit HAS_EXT1 = 1'b0
)(
   input  wire logic [1:0] dest_sel,
   input  wire logic       level,
   output isr_dest_t       dest
);
   // steer the level onto one line, or onto none for selector 3 when HAS_EXT1 is clear
   always_comb begin
      dest = '0;
      case (dest_sel)
         `ISR_DEST_ICPU0: dest.icpu0 = level;
         `ISR_DEST_ICPU1: dest.icpu1 = level;
         `ISR_DEST_EXT0:  dest.ext0  = level;
         default:         dest.ext1  = HAS_EXT1 ? level : 1'b0;
      endcase
   end
endmodule : isr_route_dec
`default_nettype wire

// ==== tb/isr_cpu_model.sv ====
// cpu side model: gathers the four interrupt lines as one struct
`timescale 1ns/10ps
`default_nettype none
module isr_cpu_model
   import isr_pkg::*;
(
   input  wire logic icpu0,
   input  wire logic icpu1,
   input  wire logic ext0,
   input  wire logic ext1,
   output isr_dest_t seen
);
   // level inputs, taken as the cpu sees them
   assign seen = '{ext1: ext1, ext0: ext0, icpu1: icpu1, icpu0: icpu0};
endmodule : isr_cpu_model
`default_nettype wire

// ==== tb/isr_route_checker.sv ====
// assertions on the ports of the routing block
`timescale 1ns/10ps
`default_nettype none
module isr_route_checker (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  srcs,
   input wire logic [3:0]  lines,
   input wire logic        irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_access_wait: assert property ($rose(penable) |=> pready)
      else $error("no answer one cycle into access");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside a transfer");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_err: assert property (pready && paddr > 12'h018 |-> pslverr)
      else $error("unmapped access not refused");
   a_unmapped_rd: assert property (pready && !pwrite && paddr > 12'h018
      |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_line_cause: assert property ($rose(|lines) |->
      $past(|srcs, 2) || $past(psel, 2) || $past(psel, 3))
      else $error("line rose without cause");
   a_reset_quiet: assert property ($fell(reset) |-> !(|lines) && !irq)
      else $error("outputs active after reset");
endmodule : isr_route_checker
bind isr_route_top isr_route_checker u_chk (.clk_sys(clk_sys),
   .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .srcs({extract_queue1_ready, extract_queue0_ready, analyzer_source,
          all_ports_source}), .irq(irq),
   .lines({external_int_out1, external_int_out0, internal_cpu_line1,
           internal_cpu_line0}));
`default_nettype wire

// ==== tb/isr_route_top_tb.sv ====
// self-checking bench for the interrupt routing block
`timescale 1ns/10ps
`default_nettype none
`include "isr_regs.svh"
module isr_route_top_tb
   import isr_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  src = 4'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, err, l0, l1, e0, e1;
   isr_dest_t   seen;
   integer      seed = 36;
   integer      num_errors = 0;
   integer      comparisons = 0;
   int          s, j;
   // clock and device under test with its cpu side
   always #2.5 clk_sys = ~clk_sys;
   isr_route_top u_isr_route_top (.clk_sys(clk_sys), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .all_ports_source(src[0]), .analyzer_source(src[1]),
      .extract_queue0_ready(src[2]), .extract_queue1_ready(src[3]),
      .internal_cpu_line0(l0), .internal_cpu_line1(l1),
      .external_int_out0(e0), .external_int_out1(e1), .irq(irq));
   isr_cpu_model u_isr_cpu_model (.icpu0(l0), .icpu1(l1), .ext0(e0),
      .ext1(e1), .seen(seen));
   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_sys);
      end
      if (n == 20) begin
         num_errors++;
         complete_run;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // wait cycles; outputs are read before the edge updates them
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask : cyc
   // expected destination lines for a source and selector
   function automatic logic [31:0] exp_l(input int sn, input int sel);
      if (sel == 3 && sn != `ISR_SRC_ANALYZER) return 32'h0;
      return 32'h1 << sel;
   endfunction : exp_l
   task automatic complete_run;
      if (num_errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   // watchdog against a hang
   initial begin
      #100000;
      num_errors++;
      complete_run;
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      for (s = 0; s < 4; s++) begin
         apb(1'b0, 12'(4 * s), 32'h0);
         chk(rd, 32'h0);
      end
      for (s = 0; s < 4; s++) for (j = 0; j < 4; j++) begin
         apb(1'b1, 12'(4 * s), 32'(j));
         src[s] <= 1'b1;
         cyc(1);
         src[s] <= 1'b0;
         cyc(4);
         chk({28'h0, seen}, exp_l(s, j));
         apb(1'b1, `ISR_OFS_PENDING, 32'h1 << s);
         cyc(3);
         chk({28'h0, seen}, 32'h0);
      end
      repeat (6) begin
         s = int'($unsigned($random(seed)) % 4);
         j = int'($unsigned($random(seed)) % 4);
         apb(1'b1, 12'(4 * s), 32'h8 | 32'(j));
         cyc(3);
         chk({28'h0, seen}, exp_l(s, j));
         apb(1'b0, 12'(4 * s), 32'h0);
         chk(rd, 32'(j));
         apb(1'b1, `ISR_OFS_PENDING, 32'h1 << s);
      end
      // software picks passthrough for the line to an outside cpu
      apb(1'b1, `ISR_OFS_ANALYZER, 32'h0000_001B);
      cyc(3);
      chk({28'h0, seen}, 32'h0);
      src[1] <= 1'b1;
      cyc(3);
      chk({28'h0, seen}, 32'h8);
      src[1] <= 1'b0;
      cyc(3);
      chk({28'h0, seen}, 32'h0);
      apb(1'b1, `ISR_OFS_STATUS, 32'hF);
      apb(1'b1, `ISR_OFS_MASK, 32'h1);
      src[0] <= 1'b1;
      cyc(4);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `ISR_OFS_MASK, 32'h0);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      // acknowledge the latch first, else status is set again
      apb(1'b1, `ISR_OFS_PENDING, 32'h1);
      apb(1'b1, `ISR_OFS_STATUS, 32'h1);
      apb(1'b0, `ISR_OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h01C, 32'h0);
      chk({31'h0, err}, 32'h1);
      complete_run;
   end
endmodule : isr_route_top_tb
`default_nettype wire
